// File: hw/rsc_reset_controller.sv
// Overview of operation
// - External reset line low resets the device and clears the program counter.
// - After the line rises, hold reset for the extension delay.
// - External line reset is a warm reset keeping part of register contents.
// - Qualified supply drop always resets and sets the supply-drop flag.
// - Supply drops no longer than the qualify time are ignored.
// - Threshold codes 55, 33, 99, aa select 2.1, 2.55, 3.15, 3.8 volts.
// - Undefined threshold code resets after 2~3 slow ticks, sets flag, restores.
// - Genuine supply-drop reset keeps the threshold select register.
// - Supply-drop reset is disabled in power-down mode.
// - Supply-drop flag at bit 2 set by hardware, cleared only by software or power-on.
// - Bad-threshold flag at bit 1 set on undefined code, software clears.
// - Flag register bits 6 to 3 read as zero.
// - Watchdog time-out while running resets like the line and sets time-out.
// - Watchdog time-out in sleep or idle clears only PC and SP.
// - Key 10101 disables watchdog, 01010 enables it, enabled after power-on.
// - Other key values reset after 2~3 slow ticks and set bad-key flag.
// - Bypass bit 4 resets to 0; when set, bus reset is ignored.
// - Bypass bit never blocks power-on reset.
// - Flash reset control bits 7 to 5 read as zero.
// - Power-on clears time-out and power-down flags; halted time-out sets both.
// - Line, supply or bus resets leave time-out and power-down flags unchanged.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`default_nettype none
module rsc_reset_controller
  import rsc_pkg::*;
#(
  parameter int unsigned RSTD_CYC =
    (RSTD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int unsigned LVR_QUAL_CYC =
    (LVR_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
)
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ext_reset_line_n_in,
  input  wire logic        low_supply_in,
  input  wire logic        powerdown_mode_in,
  input  wire logic        sleep_idle_mode_in,
  input  wire logic        watchdog_timeout_in,
  input  wire logic        sie_bus_reset_in,
  input  wire logic [7:0]  axi_awaddr_in,
  input  wire logic        axi_awvalid_in,
  output logic             axi_awready_out,
  input  wire logic [31:0] axi_wdata_in,
  input  wire logic [3:0]  axi_wstrb_in,
  input  wire logic        axi_wvalid_in,
  output logic             axi_wready_out,
  output logic [1:0]       axi_bresp_out,
  output logic             axi_bvalid_out,
  input  wire logic        axi_bready_in,
  input  wire logic [7:0]  axi_araddr_in,
  input  wire logic        axi_arvalid_in,
  output logic             axi_arready_out,
  output logic [31:0]      axi_rdata_out,
  output logic [1:0]       axi_rresp_out,
  output logic             axi_rvalid_out,
  input  wire logic        axi_rready_in,
  output logic             sys_reset_out,
  output logic             cold_reset_out,
  output logic             pc_sp_clear_out,
  output logic             watchdog_enable_out,
  output logic [2:0]       watchdog_period_out,
  output logic [1:0]       threshold_level_out
);
  typedef struct packed {
    rsc_state_t       st;
    logic             cold;
    logic             ext_meta;
    logic             ext_sync;
    logic             lvd_meta;
    logic             lvd_sync;
    logic [7:0]       thr_code;
    logic [7:0]       wdt_ctrl;
    logic             bypass;
    logic             lvr_flag;
    logic             thr_flag;
    logic             wdt_flag;
    logic             to_flag;
    logic             pd_flag;
    logic             pc_clear;
    logic [DIV_W-1:0] div;
    logic [1:0]       thr_cnt;
    logic [1:0]       wdt_cnt;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [7:0]       wdata;
    logic             wstb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
  } rsc_ctl_t;
  // The line synchroniser idles high so a power-on does not add a warm reset.
  localparam rsc_ctl_t RST_VAL = '{
    st:       RSC_HOLD,
    cold:     1'b1,
    ext_meta: 1'b1,
    ext_sync: 1'b1,
    thr_code: THR_POR,
    wdt_ctrl: WDT_POR,
    bypass:   BYPASS_POR,
    default:  '0
  };
  rsc_ctl_t s_ff;
  rsc_ctl_t nxt_s;
  logic lvr_done;
  logic ext_done;
  logic ext_low;
  logic thr_bad;
  logic wdt_bad;
  logic thr_fire;
  logic wdt_fire;
  logic wdt_en;
  logic wdt_to_run;
  logic wdt_to_halt;
  logic sie_rst;
  logic req;
  logic restore_thr;
  logic slow_tick;
  logic wr_fire;
  // Power-down masks the detector before the qualification count.
  rsc_hold_filter #(
    .CYCLES (LVR_QUAL_CYC + 1)
  ) u_lvr_qual (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .level_in (s_ff.lvd_sync && !powerdown_mode_in),
    .done_out (lvr_done)
  );
  rsc_hold_filter #(
    .CYCLES (RSTD_CYC)
  ) u_extend (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .level_in ((s_ff.st == RSC_EXTEND) && !req),
    .done_out (ext_done)
  );
  assign ext_low     = !s_ff.ext_sync;
  assign thr_bad     = !(s_ff.thr_code inside
                         {THR_POR, THR_2V55, THR_3V15, THR_3V80});
  assign wdt_bad     = !(s_ff.wdt_ctrl[KEY_MSB:KEY_LSB] inside
                         {KEY_OFF, KEY_ON});
  assign wdt_en      = (s_ff.wdt_ctrl[KEY_MSB:KEY_LSB] == KEY_ON);
  assign thr_fire    = (s_ff.thr_cnt == KEY_TICKS);
  assign wdt_fire    = (s_ff.wdt_cnt == KEY_TICKS);
  assign wdt_to_run  = watchdog_timeout_in && wdt_en
                       && !sleep_idle_mode_in;
  assign wdt_to_halt = watchdog_timeout_in && wdt_en
                       && sleep_idle_mode_in;
  assign sie_rst     = sie_bus_reset_in && !s_ff.bypass;
  assign slow_tick   = (s_ff.div == SLOW_DIV_LAST);
  assign wr_fire     = s_ff.aw_got && s_ff.w_got;
  // A supply drop alone leaves the threshold code where it was.
  assign restore_thr = !rst_n_in || ext_low || wdt_to_run || thr_fire
                       || wdt_fire || sie_rst;
  assign req = restore_thr || lvr_done;
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.ext_meta = ext_reset_line_n_in;
    nxt_s.ext_sync = s_ff.ext_meta;
    nxt_s.lvd_meta = low_supply_in;
    nxt_s.lvd_sync = s_ff.lvd_meta;
    nxt_s.pc_clear = wdt_to_halt;
    nxt_s.div = slow_tick ? '0 : s_ff.div + 1'b1;
    // The tick phase is free running, so three ticks give 2~3 periods.
    if (!thr_bad)
      nxt_s.thr_cnt = '0;
    else if (slow_tick && !thr_fire)
      nxt_s.thr_cnt = s_ff.thr_cnt + 1'b1;
    if (!wdt_bad)
      nxt_s.wdt_cnt = '0;
    else if (slow_tick && !wdt_fire)
      nxt_s.wdt_cnt = s_ff.wdt_cnt + 1'b1;
    case (s_ff.st)
      RSC_RUN:
        if (req)
          nxt_s.st = RSC_HOLD;
      RSC_HOLD:
        if (!req)
          nxt_s.st = RSC_EXTEND;
      RSC_EXTEND:
        if (req)
          nxt_s.st = RSC_HOLD;
        else if (ext_done)
        begin
          nxt_s.st = RSC_RUN;
          nxt_s.cold = 1'b0;
        end
      default:
        nxt_s.st = RSC_HOLD;
    endcase
    // Write channel: address and data are taken in either order.
    if (axi_awvalid_in && axi_awready_out)
    begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && axi_wready_out)
    begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = axi_wdata_in[7:0];
      nxt_s.wstb  = axi_wstrb_in[0];
    end
    if (s_ff.bvalid && axi_bready_in)
      nxt_s.bvalid = 1'b0;
    if (wr_fire)
    begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got  = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp  = RESP_OKAY;
      case (s_ff.awaddr)
        ADDR_THR:
          if (s_ff.wstb)
            nxt_s.thr_code = s_ff.wdata;
        ADDR_FLAGS:
          if (s_ff.wstb)
          begin
            nxt_s.lvr_flag = s_ff.wdata[FLAG_LVR];
            nxt_s.thr_flag = s_ff.wdata[FLAG_THR];
            nxt_s.wdt_flag = s_ff.wdata[FLAG_WDT];
          end
        ADDR_WDT:
          if (s_ff.wstb)
            nxt_s.wdt_ctrl = s_ff.wdata;
        ADDR_FLASH:
          if (s_ff.wstb)
            nxt_s.bypass = s_ff.wdata[BYPASS_BIT];
        ADDR_STATUS:
          nxt_s.bresp = RESP_OKAY;
        default:
          nxt_s.bresp = RESP_DECERR;
      endcase
    end
    // Read channel answers one cycle after the address is taken.
    if (s_ff.rvalid && axi_rready_in)
      nxt_s.rvalid = 1'b0;
    if (axi_arvalid_in && axi_arready_out)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp  = RESP_OKAY;
      nxt_s.rdata  = '0;
      case (axi_araddr_in)
        ADDR_THR:
          nxt_s.rdata = s_ff.thr_code;
        ADDR_FLAGS:
        begin
          nxt_s.rdata[FLAG_LVR] = s_ff.lvr_flag;
          nxt_s.rdata[FLAG_THR] = s_ff.thr_flag;
          nxt_s.rdata[FLAG_WDT] = s_ff.wdt_flag;
        end
        ADDR_WDT:
          nxt_s.rdata = s_ff.wdt_ctrl;
        ADDR_FLASH:
          nxt_s.rdata[BYPASS_BIT] = s_ff.bypass;
        ADDR_STATUS:
        begin
          nxt_s.rdata[STAT_TO] = s_ff.to_flag;
          nxt_s.rdata[STAT_PD] = s_ff.pd_flag;
        end
        default:
          nxt_s.rresp = RESP_DECERR;
      endcase
    end
    // Hardware sets follow the software write so a set is never lost.
    if (lvr_done)
      nxt_s.lvr_flag = 1'b1;
    if (thr_bad)
      nxt_s.thr_flag = 1'b1;
    if (wdt_bad)
      nxt_s.wdt_flag = 1'b1;
    if (wdt_to_run || wdt_to_halt)
      nxt_s.to_flag = 1'b1;
    if (wdt_to_halt)
      nxt_s.pd_flag = 1'b1;
    if (restore_thr)
      nxt_s.thr_code = THR_POR;
    if (req)
    begin
      nxt_s.wdt_ctrl = WDT_POR;
      nxt_s.bypass   = BYPASS_POR;
    end
  end
  // Power-on alone brings back the flags and the cold marker.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      s_ff <= RST_VAL;
    else
      s_ff <= nxt_s;
  end
  // Assertion of reset is combinational from the merged request, so it
  // arrives in the same cycle; release waits for the clocked state machine.
  assign sys_reset_out       = req || (s_ff.st != RSC_RUN);
  assign cold_reset_out      = s_ff.cold;
  assign pc_sp_clear_out     = s_ff.pc_clear;
  assign watchdog_enable_out = wdt_en;
  assign watchdog_period_out = s_ff.wdt_ctrl[PER_MSB:0];
  assign axi_awready_out     = !s_ff.aw_got && !s_ff.bvalid;
  assign axi_wready_out      = !s_ff.w_got && !s_ff.bvalid;
  assign axi_bvalid_out      = s_ff.bvalid;
  assign axi_bresp_out       = s_ff.bresp;
  assign axi_arready_out     = !s_ff.rvalid;
  assign axi_rvalid_out      = s_ff.rvalid;
  assign axi_rresp_out       = s_ff.rresp;
  assign axi_rdata_out       = {24'h0, s_ff.rdata};
  always_comb
  begin
    case (s_ff.thr_code)
      THR_2V55: threshold_level_out = LVL_2V55;
      THR_3V15: threshold_level_out = LVL_3V15;
      THR_3V80: threshold_level_out = LVL_3V80;
      default:  threshold_level_out = LVL_2V10;
    endcase
  end

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_POR: assert property (disable iff (1'b0)
    !rst_n_in |=> sys_reset_out && cold_reset_out
                  && !s_ff.to_flag && !s_ff.pd_flag)
    else $error("power-on did not reset or clear flags");
  AST_EXT_LOW: assert property (
    ext_low |-> sys_reset_out)
    else $error("line low without internal reset");
  AST_EXTEND: assert property (
    $fell(sys_reset_out) |-> $past(s_ff.st == RSC_EXTEND) && $past(ext_done))
    else $error("reset released before extension delay");
  AST_LVR: assert property (
    lvr_done |-> sys_reset_out ##1 s_ff.lvr_flag)
    else $error("supply drop did not reset and flag");
  AST_LVR_FILTER: assert property (
    $rose(s_ff.lvd_sync) |-> !lvr_done [*8])
    else $error("short supply drop caused a reset");
  AST_THR_BAD: assert property (
    $rose(thr_bad) |=> s_ff.thr_flag && !thr_fire && !sys_reset_out)
    else $error("bad threshold code not flagged or reset too early");
  AST_THR_KEEP: assert property (
    lvr_done && !restore_thr && !wr_fire |=> $stable(s_ff.thr_code))
    else $error("supply drop reset changed threshold code");
  AST_PD: assert property (
    powerdown_mode_in && $past(powerdown_mode_in) |-> !lvr_done)
    else $error("supply drop reset active in power-down");
  AST_WDT_RUN: assert property (
    wdt_to_run |-> sys_reset_out ##1 s_ff.to_flag)
    else $error("running time-out did not reset and flag");
  AST_WDT_HALT: assert property (
    wdt_to_halt |=> pc_sp_clear_out && s_ff.to_flag && s_ff.pd_flag)
    else $error("halted time-out did not clear PC or set flags");
  AST_WDT_KEY: assert property (
    $rose(wdt_bad) |=> s_ff.wdt_flag)
    else $error("bad watchdog key not flagged");
  AST_BYPASS: assert property (
    s_ff.bypass && (s_ff.st == RSC_RUN) && !ext_low && !lvr_done
    && !watchdog_timeout_in && !thr_fire && !wdt_fire |-> !sys_reset_out)
    else $error("bus reset not bypassed");
  AST_FLAGS_KEEP: assert property (
    (ext_low || sie_rst) && !watchdog_timeout_in
    |=> $stable(s_ff.to_flag) && $stable(s_ff.pd_flag))
    else $error("time-out or power-down flag changed");
endmodule
`default_nettype wire

// File: hw/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Register byte addresses on the bus.
  localparam logic [7:0] ADDR_THR    = 8'h00;
  localparam logic [7:0] ADDR_FLAGS  = 8'h04;
  localparam logic [7:0] ADDR_WDT    = 8'h08;
  localparam logic [7:0] ADDR_FLASH  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Threshold select codes and their level encodings.
  localparam logic [7:0] THR_POR  = 8'h55;
  localparam logic [7:0] THR_2V55 = 8'h33;
  localparam logic [7:0] THR_3V15 = 8'h99;
  localparam logic [7:0] THR_3V80 = 8'haa;
  localparam logic [1:0] LVL_2V10 = 2'h0;
  localparam logic [1:0] LVL_2V55 = 2'h1;
  localparam logic [1:0] LVL_3V15 = 2'h2;
  localparam logic [1:0] LVL_3V80 = 2'h3;

  // Watchdog key control layout.
  localparam logic [7:0] WDT_POR = 8'h53;
  localparam int unsigned KEY_MSB = 7;
  localparam int unsigned KEY_LSB = 3;
  localparam int unsigned PER_MSB = 2;
  localparam logic [4:0] KEY_OFF = 5'h15;
  localparam logic [4:0] KEY_ON  = 5'h0a;

  // Flag and control bit positions.
  localparam int unsigned FLAG_LVR   = 2;
  localparam int unsigned FLAG_THR   = 1;
  localparam int unsigned FLAG_WDT   = 0;
  localparam int unsigned BYPASS_BIT = 4;
  localparam int unsigned STAT_TO    = 0;
  localparam int unsigned STAT_PD    = 1;
  localparam logic BYPASS_POR = 1'b0;

  // Slow oscillator tick, derived from the system clock.
  localparam int unsigned SLOW_PERIOD_NS = 31250;
  localparam int unsigned DIV_W = 12;
  localparam logic [DIV_W-1:0] SLOW_DIV_LAST =
    DIV_W'(SLOW_PERIOD_NS / CLK_PERIOD_NS - 1);
  localparam logic [1:0] KEY_TICKS = 2'h3;

  // Reset extension and supply drop qualification times.
  localparam int unsigned RSTD_NS     = 100000;
  localparam int unsigned LVR_QUAL_NS = 50000;

  typedef enum logic [1:0] {RSC_RUN, RSC_HOLD, RSC_EXTEND} rsc_state_t;
endpackage
`default_nettype wire

// File: hw/rsc_hold_filter.sv
`default_nettype none
module rsc_hold_filter
  import rsc_pkg::*;
#(
  parameter int unsigned CYCLES = 1
)
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  output logic      done_out
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } rsc_hold_t;

  rsc_hold_t s_ff;
  rsc_hold_t nxt_s;

  // The count saturates so a long level keeps done high without wrapping.
  always_comb
  begin
    nxt_s = s_ff;
    if (!level_in)
      nxt_s.cnt = '0;
    else if (s_ff.cnt != CW'(CYCLES))
      nxt_s.cnt = s_ff.cnt + 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign done_out = (s_ff.cnt == CW'(CYCLES));
endmodule
`default_nettype wire

// File: bench/rsc_far_side.sv
`default_nettype none
module rsc_far_side
(
  input  wire logic clk_in,
  output logic      ext_reset_line_n_out,
  output logic      low_supply_out,
  output logic      bus_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bench loads a count; each source stays active that many cycles.
  int line_cnt = 0;
  int drop_cnt = 0;
  int bus_cnt  = 0;
  initial
  begin
    ext_reset_line_n_out = 1'b1;
    low_supply_out = 1'b0;
    bus_reset_out = 1'b0;
  end
  // The reset line is driven high whenever no line count is running.
  always @(posedge clk_in)
  begin
    ext_reset_line_n_out <= (line_cnt == 0);
    low_supply_out <= (drop_cnt != 0);
    bus_reset_out <= (bus_cnt != 0);
    // A count is written only while it runs, so a load from the bench at
    // the same edge is never overwritten by a stale zero.
    if (line_cnt > 0)
      line_cnt <= line_cnt - 1;
    if (drop_cnt > 0)
      drop_cnt <= drop_cnt - 1;
    if (bus_cnt > 0)
      bus_cnt <= bus_cnt - 1;
  end
endmodule
`default_nettype wire

// File: bench/rsc_reset_controller_bench.sv
`default_nettype none
module rsc_reset_controller_bench
  import rsc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RSTD = 20;
  localparam int QUAL = 10;
  localparam int SLOW = int'(SLOW_DIV_LAST) + 1;
  logic        clk_in = 1'b0, rst_n_in = 1'b0;
  logic        powerdown_mode_in = 1'b0, sleep_idle_mode_in = 1'b0;
  logic        watchdog_timeout_in = 1'b0;
  logic [7:0]  axi_awaddr_in = 8'h00, axi_araddr_in = 8'h00;
  logic [31:0] axi_wdata_in = 32'h0;
  logic [3:0]  axi_wstrb_in = 4'h1;
  logic        axi_awvalid_in = 1'b0, axi_wvalid_in = 1'b0;
  logic        axi_bready_in = 1'b0, axi_arvalid_in = 1'b0;
  logic        axi_rready_in = 1'b0;
  logic [1:0]  rresp_seen;
  wire logic   ext_reset_line_n_in, low_supply_in, sie_bus_reset_in;
  wire logic   axi_awready_out, axi_wready_out, axi_bvalid_out;
  wire logic   axi_arready_out, axi_rvalid_out;
  wire logic [1:0]  axi_bresp_out, axi_rresp_out, threshold_level_out;
  wire logic [31:0] axi_rdata_out;
  wire logic   sys_reset_out, cold_reset_out, pc_sp_clear_out;
  wire logic   watchdog_enable_out;
  wire logic [2:0]  watchdog_period_out;
  int          num_errors = 0;
  int          checked = 0;
  rsc_reset_controller #(.RSTD_CYC(RSTD), .LVR_QUAL_CYC(QUAL)) dut
  (
    .clk_in, .rst_n_in, .ext_reset_line_n_in, .low_supply_in,
    .powerdown_mode_in, .sleep_idle_mode_in, .watchdog_timeout_in,
    .sie_bus_reset_in, .axi_awaddr_in, .axi_awvalid_in, .axi_awready_out,
    .axi_wdata_in, .axi_wstrb_in, .axi_wvalid_in, .axi_wready_out,
    .axi_bresp_out, .axi_bvalid_out, .axi_bready_in, .axi_araddr_in,
    .axi_arvalid_in, .axi_arready_out, .axi_rdata_out, .axi_rresp_out,
    .axi_rvalid_out, .axi_rready_in, .sys_reset_out, .cold_reset_out,
    .pc_sp_clear_out, .watchdog_enable_out, .watchdog_period_out,
    .threshold_level_out
  );
  rsc_far_side far
  (
    .clk_in,
    .ext_reset_line_n_out(ext_reset_line_n_in),
    .low_supply_out(low_supply_in),
    .bus_reset_out(sie_bus_reset_in)
  );
  initial
    forever #4 clk_in = ~clk_in;
  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Every wait on a handshake or on sys_reset_out goes through here, so a hang ends the run with a verdict.
  task automatic tick(inout int n, input int lim);
    @(posedge clk_in);
    n++;
    if (n > lim)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    logic ta = 1'b0, tw = 1'b0;
    axi_awaddr_in <= a;
    axi_wdata_in <= {24'h0, d};
    axi_awvalid_in <= 1'b1;
    axi_wvalid_in <= 1'b1;
    axi_bready_in <= 1'b1;
    while (!(ta && tw))
    begin
      tick(n, 50);
      ta = ta | axi_awready_out;
      tw = tw | axi_wready_out;
      axi_awvalid_in <= !ta;
      axi_wvalid_in <= !tw;
    end
    do
      tick(n, 50);
    while (axi_bvalid_out !== 1'b1);
    chk(axi_bresp_out, RESP_OKAY);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    int n = 0;
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'b1;
    axi_rready_in <= 1'b1;
    do
      tick(n, 50);
    while (axi_arready_out !== 1'b1);
    axi_arvalid_in <= 1'b0;
    do
      tick(n, 50);
    while (axi_rvalid_out !== 1'b1);
    rresp_seen = axi_rresp_out;
    chk(axi_rdata_out, exp);
  endtask
  task automatic wait_sys(input logic lv, input int lim, output int n);
    n = 0;
    while (sys_reset_out !== lv)
      tick(n, lim);
  endtask
  task automatic watch(input int cyc, output int hi);
    hi = 0;
    repeat (cyc)
    begin
      @(posedge clk_in);
      hi += int'(sys_reset_out !== 1'b0);
    end
  endtask
  task automatic to_pulse(output logic r);
    watchdog_timeout_in <= 1'b1;
    @(posedge clk_in);
    r = sys_reset_out;
    watchdog_timeout_in <= 1'b0;
  endtask
  task automatic power_on;
    int n;
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    chk(sys_reset_out, 1'b1);
    chk(cold_reset_out, 1'b1);
    rst_n_in <= 1'b1;
    wait_sys(1'b0, RSTD + 10, n);
    chk(n >= RSTD, 1'b1);
  endtask
  task automatic s_defaults;
    rdchk(ADDR_THR, THR_POR);
    rdchk(ADDR_WDT, WDT_POR);
    rdchk(ADDR_FLASH, 8'h00);
    rdchk(ADDR_FLAGS, 8'h00);
    rdchk(ADDR_STATUS, 8'h00);
    rdchk(8'h14, 32'h0);
    chk(rresp_seen, RESP_DECERR);
    chk(watchdog_enable_out, 1'b1);
  endtask
  task automatic s_levels;
    logic [7:0] code [4] = '{THR_2V55, THR_3V15, THR_3V80, THR_POR};
    logic [1:0] lvl [4] = '{LVL_2V55, LVL_3V15, LVL_3V80, LVL_2V10};
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_THR, code[i]);
      chk(threshold_level_out, lvl[i]);
      rdchk(ADDR_THR, code[i]);
    end
    wr(ADDR_FLASH, 8'hff);
    rdchk(ADDR_FLASH, 8'h10);
    wr(ADDR_FLASH, 8'h00);
  endtask
  task automatic s_supply;
    int hi;
    int n;
    wr(ADDR_THR, THR_2V55);
    far.drop_cnt <= QUAL / 2;
    watch(QUAL * 4, hi);
    chk(hi, 0);
    powerdown_mode_in <= 1'b1;
    far.drop_cnt <= QUAL * 4;
    watch(QUAL * 6, hi);
    chk(hi, 0);
    powerdown_mode_in <= 1'b0;
    far.drop_cnt <= QUAL * 4;
    wait_sys(1'b1, QUAL + 8, n);
    chk(n > QUAL, 1'b1);
    wait_sys(1'b0, QUAL * 4 + RSTD + 10, n);
    rdchk(ADDR_FLAGS, 8'h04);
    rdchk(ADDR_THR, THR_2V55);
    rdchk(ADDR_STATUS, 8'h00);
    wr(ADDR_FLAGS, 8'h00);
    rdchk(ADDR_FLAGS, 8'h00);
  endtask
  task automatic s_badcode(input logic [7:0] a, input logic [7:0] c,
                           input logic [7:0] f, input logic [7:0] por);
    int n;
    wr(a, c);
    wait_sys(1'b1, 3 * SLOW + 20, n);
    chk(n >= 2 * SLOW - 10, 1'b1);
    wait_sys(1'b0, RSTD + 10, n);
    rdchk(ADDR_FLAGS, f);
    rdchk(a, por);
    wr(ADDR_FLAGS, 8'h00);
  endtask
  task automatic s_watchdog;
    int n;
    logic r;
    wr(ADDR_WDT, 8'hab);
    chk(watchdog_enable_out, 1'b0);
    to_pulse(r);
    chk(r, 1'b0);
    wr(ADDR_WDT, WDT_POR);
    chk(watchdog_period_out, 3'h3);
    to_pulse(r);
    chk(r, 1'b1);
    wait_sys(1'b0, RSTD + 10, n);
    rdchk(ADDR_STATUS, 8'h01);
    sleep_idle_mode_in <= 1'b1;
    to_pulse(r);
    chk(r, 1'b0);
    @(posedge clk_in);
    chk(pc_sp_clear_out, 1'b1);
    sleep_idle_mode_in <= 1'b0;
    rdchk(ADDR_STATUS, 8'h03);
  endtask
  task automatic s_bus_ext;
    int hi;
    int n;
    wr(ADDR_FLASH, 8'h10);
    far.bus_cnt <= 10;
    watch(20, hi);
    chk(hi, 0);
    wr(ADDR_FLASH, 8'h00);
    far.bus_cnt <= 10;
    wait_sys(1'b1, 3, n);
    wait_sys(1'b0, RSTD + 20, n);
    far.line_cnt <= 30;
    wait_sys(1'b1, 5, n);
    wait_sys(1'b0, RSTD + 40, n);
    chk(n >= RSTD + 28, 1'b1);
    chk(cold_reset_out, 1'b0);
    rdchk(ADDR_STATUS, 8'h03);
  endtask
  initial
  begin
    power_on();
    s_defaults();
    s_levels();
    s_supply();
    s_badcode(ADDR_THR, 8'h12, 8'h02, THR_POR);
    s_badcode(ADDR_WDT, 8'h23, 8'h01, WDT_POR);
    s_watchdog();
    s_bus_ext();
    wr(ADDR_FLASH, 8'h10);
    power_on();
    rdchk(ADDR_STATUS, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
